// *** verilog/relay_port_pkg.sv ***
// constants shared by the relay and isolated input port
package relay_port_pkg;
	localparam int         CHANNELS        = 8;
	localparam int         ID_BITS         = 4;
	localparam int         OFFSET_BITS     = 5;
	localparam int         WINDOW_BYTES    = 32;
	localparam int         IO_ADDR_BITS    = 16;
	localparam logic [4:0] OFS_RELAY       = 5'h00;
	localparam logic [4:0] OFS_INPUTS      = 5'h01;
	localparam logic [4:0] OFS_CARD_ID     = 5'h02;
	localparam logic [4:0] OFS_IRQ_ENABLE  = 5'h03;
	localparam logic [4:0] OFS_IRQ_EDGE    = 5'h04;
	localparam logic [4:0] OFS_IRQ_PENDING = 5'h05;
	localparam logic [7:0] RELAY_RESET     = 8'h00;
	localparam logic [7:0] ENABLE_RESET    = 8'h00;
	localparam logic [7:0] EDGE_RESET      = 8'h00;
	localparam logic [7:0] PENDING_RESET   = 8'h00;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;
	localparam logic       EDGE_RISING     = 1'b0;
	localparam logic       EDGE_FALLING    = 1'b1;
endpackage : relay_port_pkg

// *** verilog/input_edge_if.sv ***
// carrier of synchronised input levels and edge pulses
`timescale 1ns/1ps
`default_nettype none
interface input_edge_if #(parameter int N = 8);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport producer (output level, output rise, output fall);
	modport consumer (input level, input rise, input fall);
endinterface : input_edge_if
`default_nettype wire

// *** verilog/input_edge_sync.sv ***
// two-stage synchroniser and edge detector for the isolated inputs
`timescale 1ns/1ps
`default_nettype none
module input_edge_sync #(
	parameter int N = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] pin_in,
	input_edge_if.producer    ev
);
	logic [N-1:0] meta_ff;
	logic [N-1:0] sync_ff;
	logic [N-1:0] prev_ff;
	logic [N-1:0] nxt_meta;
	logic [N-1:0] nxt_sync;
	logic [N-1:0] nxt_prev;

	// next values of the three stages
	always_comb begin
		nxt_meta = pin_in;
		nxt_sync = meta_ff; // only reader of the first stage
		nxt_prev = sync_ff;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= nxt_meta; // stages track the pins while held
			sync_ff <= nxt_sync;
			prev_ff <= nxt_sync; // no false edge pulse right after release
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	// one pulse per clean transition, per channel
	for (genvar i = 0; i < N; i++) begin : g_edge
		assign ev.rise[i] = sync_ff[i] & ~prev_ff[i];
		assign ev.fall[i] = ~sync_ff[i] & prev_ff[i];
	end
	assign ev.level = sync_ff;
endmodule : input_edge_sync
`default_nettype wire

// *** verilog/relay_out_isolated_in_port.sv ***
// host register block driving relays and watching isolated inputs
//
// Contract
// - decode a 32-byte window in host I/O space, registers by byte offset.
// - write to offset 0 loads the eight relay control bits.
// - read of offset 0 returns present relay output state.
// - reset forces all relay control bits to zero.
// - bit zero selects normally-closed contact, bit one selects normally-open.
// - offset 1 reads synchronised input levels; writes do nothing.
// - offset 2 reads four-bit card identifier in low bits; writes ignored.
// - offset 3 holds read/write per-channel interrupt enables.
// - offset 4 holds edge selects: zero rising, one falling.
// - offset 5 reads the eight pending flags.
// - writing one at offset 5 clears that flag; zero leaves it.
`timescale 1ns/1ps
`default_nettype none
module relay_out_isolated_in_port
	import relay_port_pkg::*;
#(
	parameter logic [15:0] WINDOW_BASE = 16'h0000
) (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic [relay_port_pkg::IO_ADDR_BITS-1:0] io_addr,
	input  wire logic                                 io_rd,
	input  wire logic                                 io_wr,
	input  wire logic [7:0]                           io_wdata,
	output logic      [7:0]                           io_rdata,
	output logic                                      io_rdata_valid,
	input  wire logic [relay_port_pkg::CHANNELS-1:0]  isolated_input_bits,
	input  wire logic [relay_port_pkg::ID_BITS-1:0]   card_identifier_bits,
	output logic      [relay_port_pkg::CHANNELS-1:0]  relay_drive_bits,
	output logic                                      irq_request
);
	import relay_port_pkg::*;

	// width of the window tag above the byte offset
	localparam int HI = IO_ADDR_BITS - OFFSET_BITS;

	// synchronised levels and edge pulses of the isolated inputs
	input_edge_if #(.N(CHANNELS)) ev ();

	// address decode
	logic [HI-1:0]           addr_tag;
	logic [HI-1:0]           base_tag;
	logic                    hit;
	logic [OFFSET_BITS-1:0]  ofs;
	logic                    rd_hit;
	logic                    wr_hit;

	// register selects and write strobes
	logic                    sel_relay;
	logic                    sel_inputs;
	logic                    sel_card_id;
	logic                    sel_enable;
	logic                    sel_edge;
	logic                    sel_pending;
	logic                    wr_relay;
	logic                    wr_enable;
	logic                    wr_edge;
	logic                    wr_pending;

	// carrier signals under local names
	logic [CHANNELS-1:0]     in_level;
	logic [CHANNELS-1:0]     in_rise;
	logic [CHANNELS-1:0]     in_fall;

	// relay control
	logic [CHANNELS-1:0]     relay_ff;
	logic [CHANNELS-1:0]     nxt_relay;

	// interrupt enable and edge select
	logic [CHANNELS-1:0]     enable_ff;
	logic [CHANNELS-1:0]     nxt_enable;
	logic [CHANNELS-1:0]     edge_sel_ff;
	logic [CHANNELS-1:0]     nxt_edge_sel;

	// per-channel trigger, clear and pending flags
	logic [CHANNELS-1:0]     chosen_edge;
	logic [CHANNELS-1:0]     trig;
	logic [CHANNELS-1:0]     clr;
	logic [CHANNELS-1:0]     pending_ff;
	logic [CHANNELS-1:0]     nxt_pending;

	// request line
	logic                    irq_ff;
	logic                    nxt_irq;

	// card identifier synchroniser
	logic [ID_BITS-1:0]      id_meta_ff;
	logic [ID_BITS-1:0]      nxt_id_meta;
	logic [ID_BITS-1:0]      id_sync_ff;
	logic [ID_BITS-1:0]      nxt_id_sync;

	// read return path
	logic [7:0]              id_word;
	logic [7:0]              rd_word;
	logic [7:0]              rdata_ff;
	logic [7:0]              nxt_rdata;
	logic                    rvalid_ff;
	logic                    nxt_rvalid;

	// input synchroniser and edge detector
	input_edge_sync #(.N(CHANNELS)) u_sync (
		.clk    (clk),
		.rst    (rst),
		.pin_in (isolated_input_bits),
		.ev     (ev.producer)
	);

	// taps on the carrier
	assign in_level = ev.level;
	assign in_rise  = ev.rise;
	assign in_fall  = ev.fall;

	// window decode on the upper address bits
	assign addr_tag = io_addr[IO_ADDR_BITS-1:OFFSET_BITS];
	assign base_tag = WINDOW_BASE[IO_ADDR_BITS-1:OFFSET_BITS];
	assign hit      = (addr_tag == base_tag);
	assign ofs      = io_addr[OFFSET_BITS-1:0];
	assign rd_hit   = io_rd & hit;
	assign wr_hit   = io_wr & hit;

	// one select per mapped offset
	assign sel_relay   = (ofs == OFS_RELAY);
	assign sel_inputs  = (ofs == OFS_INPUTS);
	assign sel_card_id = (ofs == OFS_CARD_ID);
	assign sel_enable  = (ofs == OFS_IRQ_ENABLE);
	assign sel_edge    = (ofs == OFS_IRQ_EDGE);
	assign sel_pending = (ofs == OFS_IRQ_PENDING);

	// write strobes; inputs and identifier take no writes
	assign wr_relay   = wr_hit & sel_relay;
	assign wr_enable  = wr_hit & sel_enable;
	assign wr_edge    = wr_hit & sel_edge;
	assign wr_pending = wr_hit & sel_pending;

	// relay next value: loads on a window write at offset zero
	always_comb begin
		nxt_relay = relay_ff;
		if (wr_relay) begin
			nxt_relay = io_wdata;
		end
	end

	// relay register, cleared by reset so no load switches at start-up
	always_ff @(posedge clk) begin
		if (rst) begin
			relay_ff <= RELAY_RESET;
		end else begin
			relay_ff <= nxt_relay;
		end
	end

	// enable next value: one bit per input channel
	always_comb begin
		nxt_enable = enable_ff;
		if (wr_enable) begin
			nxt_enable = io_wdata;
		end
	end

	// enable register, all channels off after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_ff <= ENABLE_RESET;
		end else begin
			enable_ff <= nxt_enable;
		end
	end

	// edge select next value: zero rising, one falling
	always_comb begin
		nxt_edge_sel = edge_sel_ff;
		if (wr_edge) begin
			nxt_edge_sel = io_wdata;
		end
	end

	// edge select register
	always_ff @(posedge clk) begin
		if (rst) begin
			edge_sel_ff <= EDGE_RESET;
		end else begin
			edge_sel_ff <= nxt_edge_sel;
		end
	end

	// per-channel trigger on the chosen edge, and clear by writing one
	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
		assign chosen_edge[i] = (edge_sel_ff[i] == EDGE_RISING) ? in_rise[i] : in_fall[i];
		assign trig[i]        = enable_ff[i] & chosen_edge[i];
		assign clr[i]         = wr_pending & io_wdata[i];
	end

	// pending next value: a new trigger wins over a clear in the same cycle
	always_comb begin
		nxt_pending = pending_ff;
		nxt_pending = nxt_pending & ~clr;
		nxt_pending = nxt_pending | trig;
	end

	// flag register; cleared only by reset or a host write of one
	always_ff @(posedge clk) begin
		if (rst) begin
			pending_ff <= PENDING_RESET;
		end else begin
			pending_ff <= nxt_pending;
		end
	end

	// request follows the next flag state, so it matches the flags exactly
	always_comb begin
		nxt_irq = |nxt_pending;
	end

	// request register
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// identifier straps through two stages
	always_comb begin
		nxt_id_meta = card_identifier_bits;
		nxt_id_sync = id_meta_ff; // only reader of the first stage
	end

	// identifier synchroniser registers
	always_ff @(posedge clk) begin
		if (rst) begin
			id_meta_ff <= '0;
			id_sync_ff <= '0;
		end else begin
			id_meta_ff <= nxt_id_meta;
			id_sync_ff <= nxt_id_sync;
		end
	end

	// identifier in the low bits, upper bits zero
	assign id_word = {{(8-ID_BITS){1'b0}}, id_sync_ff};

	// read word for the addressed register; unmapped offsets read as zero
	always_comb begin
		rd_word = UNMAPPED_READ;
		if (sel_relay) begin
			rd_word = relay_ff;
		end else if (sel_inputs) begin
			rd_word = in_level;
		end else if (sel_card_id) begin
			rd_word = id_word;
		end else if (sel_enable) begin
			rd_word = enable_ff;
		end else if (sel_edge) begin
			rd_word = edge_sel_ff;
		end else if (sel_pending) begin
			rd_word = pending_ff;
		end
	end

	// read data next value: holds the last read between reads
	always_comb begin
		nxt_rdata = rdata_ff;
		if (rd_hit) begin
			nxt_rdata = rd_word;
		end
	end

	// read data register
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// read valid: one cycle after each accepted read
	always_comb begin
		nxt_rvalid = rd_hit;
	end

	// read valid register
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= nxt_rvalid;
		end
	end

	// bus outputs straight from flip-flops
	assign io_rdata         = rdata_ff;
	assign io_rdata_valid   = rvalid_ff;

	// relay drive and request line
	assign relay_drive_bits = relay_ff;
	assign irq_request      = irq_ff;
endmodule : relay_out_isolated_in_port
`default_nettype wire

// *** dv/relay_port_monitor.sv ***
// concurrent checks on the relay port pins
`timescale 1ns/1ps
`default_nettype none
module relay_port_monitor #(parameter logic [15:0] WINDOW_BASE = 16'h0000) (
	input wire logic		clk,
	input wire logic		rst,
	input wire logic [15:0]	io_addr,
	input wire logic		io_rd,
	input wire logic		io_wr,
	input wire logic [7:0]	io_wdata,
	input wire logic [7:0]	io_rdata,
	input wire logic		io_rdata_valid,
	input wire logic [7:0]	relay_drive_bits,
	input wire logic		irq_request
);
	// window decode and flag clear seen at the pins
	wire logic			hit = io_addr[15:5] == WINDOW_BASE[15:5];
	wire logic [4:0]	ofs = io_addr[4:0];
	wire logic			clr = io_wr && hit && ofs == 5'h05 && |io_wdata;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_rd; io_rd && hit; endsequence
	property p_wr; io_wr && hit && ofs == 5'h00 |=> relay_drive_bits == $past(io_wdata); endproperty
	a_wr: assert property (p_wr) else $error("relay load");
	property p_rv; s_rd |=> io_rdata_valid; endproperty
	a_rv: assert property (p_rv) else $error("no valid");
	property p_nv; !(io_rd && hit) |=> !io_rdata_valid; endproperty
	a_nv: assert property (p_nv) else $error("stray valid");
	property p_r0; s_rd ##0 ofs == 5'h00 |=> io_rdata == $past(relay_drive_bits); endproperty
	a_r0: assert property (p_r0) else $error("relay read");
	property p_rs; disable iff (1'b0) rst |=> relay_drive_bits == 8'h00; endproperty
	a_rs: assert property (p_rs) else $error("reset");
	property p_ks; io_wr && !(hit && ofs == 5'h00) |=> $stable(relay_drive_bits); endproperty
	a_ks: assert property (p_ks) else $error("relay moved");
	property p_iq; irq_request && !clr && !$past(clr) |=> irq_request; endproperty
	a_iq: assert property (p_iq) else $error("irq dropped");
	property p_un; s_rd ##0 ofs > 5'h05 |=> io_rdata == 8'h00; endproperty
	a_un: assert property (p_un) else $error("unmapped");
endmodule : relay_port_monitor
bind relay_out_isolated_in_port relay_port_monitor #(.WINDOW_BASE(WINDOW_BASE)) u_mon (.clk, .rst, .io_addr,
	.io_rd, .io_wr, .io_wdata, .io_rdata, .io_rdata_valid, .relay_drive_bits, .irq_request);
`default_nettype wire

// *** dv/relay_field_model.sv ***
// field side: opto inputs and relay contacts
`timescale 1ns/1ps
`default_nettype none
module relay_field_model (
	input wire logic [7:0]	relay_drive_bits,
	input wire logic [7:0]	drive_levels,
	output logic [7:0]		isolated_input_bits,
	output logic [7:0]		on_normally_open
);
	// inputs follow applied levels; a set bit moves common to normally open
	assign isolated_input_bits = drive_levels;
	assign on_normally_open = relay_drive_bits;
endmodule : relay_field_model
`default_nettype wire

// *** dv/tb.sv ***
// bench for the relay and input port
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [10:0] HI = 11'h018;
	logic clk = 1'b0, rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0, io_rdata_valid, irq_request;
	logic [15:0] io_addr = 16'h0000;
	logic [7:0] io_wdata = 8'h00, lv = 8'h3c, io_rdata, relay_drive_bits, isolated_input_bits, no_side;
	logic [3:0] card_id = 4'h9;
	int failures = 0, compares = 0, cycles = 0;
	// design and field model
	relay_out_isolated_in_port #(.WINDOW_BASE({HI, 5'h00})) u_dut (.clk, .rst, .io_addr, .io_rd, .io_wr, .io_wdata,
		.io_rdata, .io_rdata_valid, .isolated_input_bits, .card_identifier_bits(card_id), .relay_drive_bits, .irq_request);
	relay_field_model u_fld (.relay_drive_bits, .drive_levels(lv), .isolated_input_bits, .on_normally_open(no_side));
	// clock and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) end_of_test(1);
	end
	// compare valid flag and byte
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		compares++;
		if (g !== e) failures++;
		if (g !== e) $display("[FAIL] %0t got %h exp %h", $time, g, e);
	endtask : chk
	// one bus cycle; o[5] moves one window up; reads compare d
	task automatic acc(input logic w, input logic [5:0] o, input logic [7:0] d);
		@(posedge clk);
		io_addr <= {HI ^ {10'h000, o[5]}, o[4:0]};
		io_wdata <= d;
		io_wr <= w;
		io_rd <= !w;
		@(posedge clk);
		io_wr <= 1'b0;
		io_rd <= 1'b0;
		#1;
		if (!w) chk({io_rdata_valid, io_rdata}, {1'b1, d});
	endtask : acc
	// verdict
	task automatic end_of_test(input int extra);
		failures += extra;
		if (failures == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// reset, then register traffic
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		acc(1'b1, 6'h00, 8'ha5);
		chk({1'b0, no_side}, 9'h0a5);
		acc(1'b1, 6'h20, 8'h00);
		acc(1'b0, 6'h00, 8'ha5);
		acc(1'b0, 6'h01, 8'h3c);
		acc(1'b0, 6'h02, 8'h09);
		acc(1'b0, 6'h07, 8'h00);
		acc(1'b1, 6'h03, 8'h0f);
		acc(1'b1, 6'h04, 8'h0a);
		@(posedge clk);
		lv <= 8'hc3;
		repeat (6) @(posedge clk);
		acc(1'b0, 6'h05, 8'h09);
		chk({8'h00, irq_request}, 9'h001);
		acc(1'b1, 6'h05, 8'h08);
		acc(1'b0, 6'h05, 8'h01);
		acc(1'b1, 6'h05, 8'h01);
		acc(1'b0, 6'h05, 8'h00);
		chk({8'h00, irq_request}, 9'h000);
		// second reset in mid-run with relays on, and a new identifier strap
		@(posedge clk);
		rst <= 1'b1;
		card_id <= 4'h6;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk({1'b0, no_side}, 9'h000);
		acc(1'b0, 6'h00, 8'h00);
		acc(1'b0, 6'h03, 8'h00);
		acc(1'b0, 6'h02, 8'h06);
		end_of_test(0);
	end
endmodule : tb
`default_nettype wire
